// ---- common/accel_pkg.sv ----
// Purpose: Shared constants and types for the accelerometer serial slave
// Assumes: Positions are byte indices of the readable map
// Notes:   Identity-free; address low bits come from a strap input
package accel_pkg;

  localparam logic [3:0] ADDR_HIGH_NIBBLE = 4'h2;
  localparam int         ADDR_LOW_BITS    = 3;
  localparam int         BYTE_BITS        = 8;
  localparam int         PTR_BITS         = 3;

  localparam logic [2:0] POS_CONTROL      = 3'h0;
  localparam logic [2:0] POS_X_HIGH       = 3'h1;
  localparam logic [2:0] POS_X_LOW        = 3'h2;
  localparam logic [2:0] POS_Y_HIGH       = 3'h3;
  localparam logic [2:0] POS_Y_LOW        = 3'h4;
  localparam logic [2:0] POS_LAST         = 3'h6;

  localparam int         BIT_SLEEP        = 0;
  localparam int         BIT_SELF_CHECK   = 1;
  localparam int         BIT_REF_CHECK    = 2;
  localparam int         BIT_THERMAL      = 3;
  localparam logic [7:0] CONTROL_RESET    = 8'h00;

  localparam int         SAMPLE_BITS      = 16;
  localparam int         RES_HIGH         = 12;
  localparam int         RES_LOW          = 10;

  typedef enum logic [2:0] {
    ACCEL_IDLE,
    ACCEL_ADDR,
    ACCEL_ADDR_ACK,
    ACCEL_RX,
    ACCEL_RX_ACK,
    ACCEL_TX,
    ACCEL_TX_ACK
  } accel_state_t;

endpackage : accel_pkg

// ---- common/accel_ctl_if.sv ----
// Purpose: Carries control settings from the link domain to the core
// Assumes: Writer toggles on each control update
// Notes:   Data is stable when the toggle is seen
`timescale 1ns/10ps
interface accel_ctl_if;
  logic [7:0] control;
  logic       update_toggle;
  modport link (output control, output update_toggle);
  modport core (input control, input update_toggle);
endinterface : accel_ctl_if

// ---- logic/accel_sample_sync.sv ----
// Purpose: Holds axis samples for the link domain, word crossing by handshake
// Assumes: Samples arrive on clk; core side latches them when the link's request toggle changes
// Notes:   Values are right-aligned and masked to the resolution
`timescale 1ns/10ps
module accel_sample_sync (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        res_is_high,
  input  wire logic [15:0] x_sample,
  input  wire logic [15:0] t_sample,
  input  wire logic [15:0] y_sample,
  input  wire logic        req_toggle,
  output logic             ack_toggle,
  output logic [15:0]      x_hold,
  output logic [15:0]      t_hold,
  output logic [15:0]      y_hold
);
  logic        req_s1_reg;
  logic        req_s2_reg;
  logic        req_s3_reg;
  logic [15:0] res_mask;

  // Unused upper bits read as zero
  assign res_mask = res_is_high ?
    {{(accel_pkg::SAMPLE_BITS - accel_pkg::RES_HIGH){1'b0}},
     {accel_pkg::RES_HIGH{1'b1}}} :
    {{(accel_pkg::SAMPLE_BITS - accel_pkg::RES_LOW){1'b0}},
     {accel_pkg::RES_LOW{1'b1}}};

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      req_s1_reg <= 1'b0;
      req_s2_reg <= 1'b0;
      req_s3_reg <= 1'b0;
    end else begin
      req_s1_reg <= req_toggle;
      req_s2_reg <= req_s1_reg;
      req_s3_reg <= req_s2_reg;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      x_hold     <= 16'h0000;
      t_hold     <= 16'h0000;
      y_hold     <= 16'h0000;
      ack_toggle <= 1'b0;
    end else if (req_s2_reg != req_s3_reg) begin
      x_hold     <= x_sample & res_mask;
      t_hold     <= t_sample & res_mask;
      y_hold     <= y_sample & res_mask;
      ack_toggle <= req_s2_reg;
    end
  end
endmodule : accel_sample_sync

// ---- logic/accel_ctl_sync.sv ----
// Purpose: Brings the control byte into the core clock domain
// Assumes: Byte is stable for several clk cycles after a toggle
// Notes:   Outputs the decoded mode bits
`timescale 1ns/10ps
module accel_ctl_sync (
  input  wire logic  clk,
  input  wire logic  rst_n,
  accel_ctl_if.core  ctl,
  output logic       sleep_select,
  output logic       self_check_enable,
  output logic       reference_check_select,
  output logic       thermal_output_select
);
  logic tog_s1_reg;
  logic tog_s2_reg;
  logic tog_s3_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tog_s1_reg <= 1'b0;
      tog_s2_reg <= 1'b0;
      tog_s3_reg <= 1'b0;
    end else begin
      tog_s1_reg <= ctl.update_toggle;
      tog_s2_reg <= tog_s1_reg;
      tog_s3_reg <= tog_s2_reg;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sleep_select           <= 1'b0;
      self_check_enable      <= 1'b0;
      reference_check_select <= 1'b0;
      thermal_output_select  <= 1'b0;
    end else if (tog_s2_reg != tog_s3_reg) begin
      sleep_select           <= ctl.control[accel_pkg::BIT_SLEEP];
      self_check_enable      <= ctl.control[accel_pkg::BIT_SELF_CHECK];
      reference_check_select <= ctl.control[accel_pkg::BIT_REF_CHECK];
      thermal_output_select  <= ctl.control[accel_pkg::BIT_THERMAL];
    end
  end
endmodule : accel_ctl_sync

// ---- logic/accel_i2c_slave_regs.sv ----
// Purpose: Two-wire serial slave with control register and data read map
// Assumes: scl is the link clock port; sda sampled on scl edges
// Notes:   Start and stop are detected on sda edges gated by scl
// Summary of operation
// - Slave only; answers when addressed
// - Data changes only while clock low
// - Start: sda falls; stop: sda rises, scl high
// - Eight bits MSB first, then acknowledge
// - Answer address 0010 plus three strap bits
// - Eighth bit direction; acknowledge pulls low
// - Control bit 0 selects sleep
// - Control bit 1 enables self check
// - Control bit 2 selects reference check
// - Control bit 3 puts thermal in X
// - Five bytes: control, X high, low, Y
// - Any of five positions starts a read
// - Pointer advances; continue while master acknowledges
// - Positions five, six zero, then wrap
// - Samples right-aligned, upper bits zero
`timescale 1ns/10ps
module accel_i2c_slave_regs #(
  parameter int SAMPLE_W = accel_pkg::SAMPLE_BITS
) (
  input  wire logic                clk,
  input  wire logic                rst_n,
  input  wire logic                scl,
  input  wire logic                sda_in,
  output logic                     sda_out,
  output logic                     sda_oe,
  input  wire logic [2:0]          addr_strap,
  input  wire logic                res_is_high,
  input  wire logic [SAMPLE_W-1:0] x_sample,
  input  wire logic [SAMPLE_W-1:0] thermal_result,
  input  wire logic [SAMPLE_W-1:0] y_sample,
  output logic                     sleep_select,
  output logic                     self_check_enable,
  output logic                     reference_check_select,
  output logic                     thermal_output_select,
  output logic                     bus_active
);
  accel_ctl_if ctl ();

  accel_pkg::accel_state_t state_reg;
  logic [7:0]  shift_reg;
  logic [3:0]  bit_cnt_reg;
  logic [2:0]  ptr_reg;
  logic        ptr_loaded_reg;
  logic [7:0]  control_reg;
  logic        ctl_tog_reg;
  logic        start_flag_reg;
  logic        start_seen_reg;
  logic        stop_flag_reg;
  logic        stop_seen_reg;
  logic        active_s1_reg;
  logic        active_s2_reg;
  logic        req_tog_reg;
  logic        ack_tog;
  logic [15:0] x_hold;
  logic [15:0] t_hold;
  logic [15:0] y_hold;
  logic        thermal_sel_link;
  logic [7:0]  tx_byte;
  logic        addr_hit;
  logic        start_pend;
  logic        stop_pend;
  logic        frame_open;
  logic        ack_s1_reg;
  logic        ack_s2_reg;
  logic [2:0]  strap_s1_reg;
  logic [2:0]  strap_s2_reg;
  logic        res_s1_reg;
  logic        res_s2_reg;

  // Start and stop: sda edges while scl high flip marker toggles
  always_ff @(negedge sda_in or negedge rst_n) begin
    if (!rst_n) begin
      start_flag_reg <= 1'b0;
    end else if (scl) begin
      start_flag_reg <= ~start_flag_reg;
    end
  end

  always_ff @(posedge sda_in or negedge rst_n) begin
    if (!rst_n) begin
      stop_flag_reg <= 1'b0;
    end else if (scl) begin
      stop_flag_reg <= ~stop_flag_reg;
    end
  end

  assign start_pend = start_flag_reg != start_seen_reg;
  assign stop_pend  = stop_flag_reg != stop_seen_reg;

  // Strap pins settle through two link-clock stages
  always_ff @(posedge scl or negedge rst_n) begin
    if (!rst_n) begin
      strap_s1_reg <= 3'h0;
      strap_s2_reg <= 3'h0;
    end else begin
      strap_s1_reg <= addr_strap;
      strap_s2_reg <= strap_s1_reg;
    end
  end

  // Snapshot acknowledge returns through two link-clock stages
  always_ff @(posedge scl or negedge rst_n) begin
    if (!rst_n) begin
      ack_s1_reg <= 1'b0;
      ack_s2_reg <= 1'b0;
    end else begin
      ack_s1_reg <= ack_tog;
      ack_s2_reg <= ack_s1_reg;
    end
  end

  // Resolution pin settles through two core-clock stages
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      res_s1_reg <= 1'b0;
      res_s2_reg <= 1'b0;
    end else begin
      res_s1_reg <= res_is_high;
      res_s2_reg <= res_s1_reg;
    end
  end

  assign addr_hit = shift_reg[7:1] ==
                    {accel_pkg::ADDR_HIGH_NIBBLE, strap_s2_reg};

  assign thermal_sel_link = control_reg[accel_pkg::BIT_THERMAL];

  // Read map byte at the current pointer
  always_comb begin
    case (ptr_reg)
      accel_pkg::POS_CONTROL: tx_byte = control_reg;
      accel_pkg::POS_X_HIGH:
        tx_byte = thermal_sel_link ? t_hold[15:8] : x_hold[15:8];
      accel_pkg::POS_X_LOW:
        tx_byte = thermal_sel_link ? t_hold[7:0] : x_hold[7:0];
      accel_pkg::POS_Y_HIGH:  tx_byte = y_hold[15:8];
      accel_pkg::POS_Y_LOW:   tx_byte = y_hold[7:0];
      default:                tx_byte = 8'h00;
    endcase
  end

  // Receive side: sample sda on scl rise
  always_ff @(posedge scl or negedge rst_n) begin
    if (!rst_n) begin
      state_reg      <= accel_pkg::ACCEL_IDLE;
      shift_reg      <= 8'h00;
      bit_cnt_reg    <= 4'h0;
      start_seen_reg <= 1'b0;
      stop_seen_reg  <= 1'b0;
    end else begin
      start_seen_reg <= start_flag_reg;
      stop_seen_reg  <= stop_flag_reg;
      if (start_pend) begin
        state_reg   <= accel_pkg::ACCEL_ADDR;
        shift_reg   <= {7'h00, sda_in};
        bit_cnt_reg <= 4'h1;
      end else if (stop_pend) begin
        state_reg   <= accel_pkg::ACCEL_IDLE;
        bit_cnt_reg <= 4'h0;
      end else begin
        case (state_reg)
          accel_pkg::ACCEL_ADDR, accel_pkg::ACCEL_RX: begin
            shift_reg   <= {shift_reg[6:0], sda_in};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
            if (bit_cnt_reg == 4'h7) begin
              state_reg <= (state_reg == accel_pkg::ACCEL_ADDR) ?
                           accel_pkg::ACCEL_ADDR_ACK :
                           accel_pkg::ACCEL_RX_ACK;
            end
          end
          accel_pkg::ACCEL_ADDR_ACK: begin
            bit_cnt_reg <= 4'h0;
            if (!addr_hit) begin
              state_reg <= accel_pkg::ACCEL_IDLE;
            end else if (shift_reg[0]) begin
              state_reg <= accel_pkg::ACCEL_TX;
            end else begin
              state_reg <= accel_pkg::ACCEL_RX;
            end
          end
          accel_pkg::ACCEL_RX_ACK: begin
            bit_cnt_reg <= 4'h0;
            state_reg   <= accel_pkg::ACCEL_RX;
          end
          accel_pkg::ACCEL_TX: begin
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
            if (bit_cnt_reg == 4'h7) begin
              state_reg <= accel_pkg::ACCEL_TX_ACK;
            end
          end
          accel_pkg::ACCEL_TX_ACK: begin
            bit_cnt_reg <= 4'h0;
            state_reg   <= sda_in ? accel_pkg::ACCEL_IDLE
                                  : accel_pkg::ACCEL_TX;
          end
          default: state_reg <= accel_pkg::ACCEL_IDLE;
        endcase
      end
    end
  end

  // Pointer and control writes on the acknowledge clock of each data byte
  always_ff @(posedge scl or negedge rst_n) begin
    if (!rst_n) begin
      ptr_reg        <= accel_pkg::POS_CONTROL;
      ptr_loaded_reg <= 1'b0;
      control_reg    <= accel_pkg::CONTROL_RESET;
      ctl_tog_reg    <= 1'b0;
    end else if (start_pend) begin
      ptr_loaded_reg <= 1'b0;
    end else if (state_reg == accel_pkg::ACCEL_RX_ACK) begin
      if (!ptr_loaded_reg) begin
        ptr_reg        <= shift_reg[2:0];
        ptr_loaded_reg <= 1'b1;
      end else begin
        control_reg <= shift_reg;
        ctl_tog_reg <= ~ctl_tog_reg;
      end
    end else if (state_reg == accel_pkg::ACCEL_TX_ACK) begin
      ptr_reg <= (ptr_reg == accel_pkg::POS_LAST) ?
                 accel_pkg::POS_CONTROL : ptr_reg + 3'h1;
    end
  end

  // Snapshot request when a read is addressed
  always_ff @(posedge scl or negedge rst_n) begin
    if (!rst_n) begin
      req_tog_reg <= 1'b0;
    end else if (state_reg == accel_pkg::ACCEL_ADDR_ACK && addr_hit &&
                 shift_reg[0] && ack_s2_reg == req_tog_reg) begin
      req_tog_reg <= ~req_tog_reg;
    end
  end

  // Drive sda on scl fall: acknowledge or data bits
  always_ff @(negedge scl or negedge rst_n) begin
    if (!rst_n) begin
      sda_oe <= 1'b0;
    end else begin
      case (state_reg)
        accel_pkg::ACCEL_ADDR_ACK: sda_oe <= addr_hit;
        accel_pkg::ACCEL_RX_ACK:   sda_oe <= 1'b1;
        accel_pkg::ACCEL_TX:
          sda_oe <= ~tx_byte[3'h7 - bit_cnt_reg[2:0]];
        default:                   sda_oe <= 1'b0;
      endcase
    end
  end

  assign sda_out = 1'b0;

  assign ctl.control       = control_reg;
  assign ctl.update_toggle = ctl_tog_reg;

  accel_ctl_sync u_ctl_sync (
    .clk                    (clk),
    .rst_n                  (rst_n),
    .ctl                    (ctl),
    .sleep_select           (sleep_select),
    .self_check_enable      (self_check_enable),
    .reference_check_select (reference_check_select),
    .thermal_output_select  (thermal_output_select)
  );

  accel_sample_sync u_sample_sync (
    .clk         (clk),
    .rst_n       (rst_n),
    .res_is_high (res_s2_reg),
    .x_sample    (x_sample),
    .t_sample    (thermal_result),
    .y_sample    (y_sample),
    .req_toggle  (req_tog_reg),
    .ack_toggle  (ack_tog),
    .x_hold      (x_hold),
    .t_hold      (t_hold),
    .y_hold      (y_hold)
  );

  // A stop ends the frame at once, without waiting for a clock rise
  assign frame_open = start_pend ||
                      (state_reg != accel_pkg::ACCEL_IDLE && !stop_pend);

  // Bus activity seen in the core domain
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      active_s1_reg <= 1'b0;
      active_s2_reg <= 1'b0;
      bus_active    <= 1'b0;
    end else begin
      active_s1_reg <= frame_open;
      active_s2_reg <= active_s1_reg;
      bus_active    <= active_s2_reg;
    end
  end
endmodule : accel_i2c_slave_regs

// ---- bench/accel_i2c_slave_regs_props.sv ----
// Purpose: Port-level checks for the serial slave
// Assumes: Sda has a pull-up; master changes sda only while scl low
// Notes:   Bound from the testbench top file
`timescale 1ns/10ps
module accel_i2c_slave_regs_props (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic scl,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic sleep_select,
  input wire logic self_check_enable,
  input wire logic reference_check_select,
  input wire logic thermal_output_select,
  input wire logic bus_active
);
  logic [3:0] idle_cnt;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      idle_cnt <= 4'h0;
    end else if (bus_active) begin
      idle_cnt <= 4'h0;
    end else if (idle_cnt != 4'hF) begin
      idle_cnt <= idle_cnt + 4'h1;
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  sequence s_start;
    scl && $fell(sda_in);
  endsequence
  sequence s_stop;
    scl && $rose(sda_in);
  endsequence
  property p_ack_low;
    sda_oe |-> !sda_out;
  endproperty
  a_ack_low: assert property (p_ack_low)
    else $error("sda driven high");
  property p_drive_scl_low;
    $changed(sda_oe) |-> !scl;
  endproperty
  a_drive_scl_low: assert property (p_drive_scl_low)
    else $error("sda drive changed while scl high");
  property p_high_phase;
    $rose(scl) |-> ##1 $stable(sda_oe) [*2];
  endproperty
  a_high_phase: assert property (p_high_phase)
    else $error("sda drive moved in scl high phase");
  property p_oe_needs_active;
    sda_oe |-> bus_active;
  endproperty
  a_oe_needs_active: assert property (p_oe_needs_active)
    else $error("sda driven outside a transfer");
  property p_start_active;
    s_start |-> ##[1:6] bus_active;
  endproperty
  a_start_active: assert property (p_start_active)
    else $error("start not seen");
  property p_stop_idle;
    s_stop |-> ##[1:6] !bus_active;
  endproperty
  a_stop_idle: assert property (p_stop_idle)
    else $error("stop not seen");
  property p_no_idle_rise;
    $rose(bus_active) |-> !(scl && sda_in);
  endproperty
  a_no_idle_rise: assert property (p_no_idle_rise)
    else $error("transfer began on idle bus");
  property p_ctl_quiet;
    idle_cnt == 4'hF |-> $stable({sleep_select, self_check_enable,
                                  reference_check_select,
                                  thermal_output_select});
  endproperty
  a_ctl_quiet: assert property (p_ctl_quiet)
    else $error("mode changed with bus idle");
endmodule : accel_i2c_slave_regs_props

// ---- bench/accel_master_model.sv ----
// Purpose: Bus master model driving scl and pulling sda
// Assumes: Sda has a pull-up; 80 ns scl period inside frames
// Notes:   Scl rests high between frames
`timescale 1ns/10ps
module accel_master_model (
  output logic      scl,
  output logic      sda_pull,
  input  wire logic sda
);
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  task automatic start();
    sda_pull = 1'b0;
    #27;
    sda_pull = 1'b1;
    #20;
    scl = 1'b0;
    #20;
  endtask : start
  task automatic stop();
    sda_pull = 1'b1;
    #20;
    scl = 1'b1;
    #20;
    sda_pull = 1'b0;
    #40;
  endtask : stop
  task automatic put_bit(input logic b, output logic r);
    sda_pull = ~b;
    #20;
    scl = 1'b1;
    #20;
    r = sda;
    #20;
    scl = 1'b0;
    #20;
  endtask : put_bit
  task automatic xfer(input logic [7:0] d, input logic ack,
                      output logic [7:0] q, output logic ack_seen);
    for (int i = 7; i >= 0; i--) begin
      put_bit(d[i], q[i]);
    end
    put_bit(ack, ack_seen);
  endtask : xfer
endmodule : accel_master_model

// ---- bench/accel_i2c_slave_regs_tb.sv ----
// Purpose: Self-checking bench for the serial slave
// Assumes: Master model on scl and sda, pull-up on sda
// Notes:   Expected bytes come from a map model in the bench
`timescale 1ns/10ps
module accel_i2c_slave_regs_tb;
  logic        clk, rst_n, scl, m_pull, sda_out, sda_oe, res_is_high;
  logic        sleep_select, self_check_enable, bus_active;
  logic        reference_check_select, thermal_output_select;
  logic [2:0]  addr_strap;
  logic [15:0] x_s, t_s, y_s;
  logic [7:0]  ctl_exp;
  wire logic   sda_in;
  int          fails, checks;
  // Wake wait, scaled down for simulation
  localparam int WAKE_CYCLES = 50;
  assign sda_in = !((sda_oe && !sda_out) || m_pull);
  accel_i2c_slave_regs dut_u (.clk(clk), .rst_n(rst_n), .scl(scl),
    .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
    .addr_strap(addr_strap), .res_is_high(res_is_high), .x_sample(x_s),
    .thermal_result(t_s), .y_sample(y_s), .sleep_select(sleep_select),
    .self_check_enable(self_check_enable),
    .reference_check_select(reference_check_select),
    .thermal_output_select(thermal_output_select),
    .bus_active(bus_active));
  accel_master_model master_u (.scl(scl), .sda_pull(m_pull), .sda(sda_in));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic check(input string n, input logic [7:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", n, exp, seen);
    end
  endtask : check
  task automatic print_verdict();
    if (fails == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : print_verdict
  task automatic wait_idle();
    repeat (6) @(posedge clk);
    for (int i = 0; i < 50 && bus_active !== 1'b0; i++) @(posedge clk);
    if (bus_active !== 1'b0) begin
      fails++;
      print_verdict();
    end
  endtask : wait_idle
  function automatic logic [7:0] exp_byte(input logic [2:0] p);
    logic [15:0] w;
    w = (ctl_exp[3] ? t_s : x_s) & (res_is_high ? 16'h0FFF : 16'h03FF);
    if (p > 3'h2) w = y_s & (res_is_high ? 16'h0FFF : 16'h03FF);
    case (p)
      3'h0: return ctl_exp;
      3'h1, 3'h3: return w[15:8];
      3'h2, 3'h4: return w[7:0];
      default: return 8'h00;
    endcase
  endfunction : exp_byte
  task automatic wr(input logic [7:0] ptr, input logic has_d,
                    input logic [7:0] d);
    logic [7:0] q;
    logic       a;
    master_u.start();
    master_u.xfer({4'h2, addr_strap, 1'b0}, 1'b1, q, a);
    check("ack_addr_w", {7'h00, a}, 8'h00);
    master_u.xfer(ptr, 1'b1, q, a);
    check("ack_ptr", {7'h00, a}, 8'h00);
    if (has_d) begin
      ctl_exp = d;
      master_u.xfer(d, 1'b1, q, a);
      check("ack_data", {7'h00, a}, 8'h00);
    end
    master_u.stop();
    wait_idle();
  endtask : wr
  task automatic rd(input logic [2:0] p0, input int n);
    logic [7:0] q;
    logic       a;
    logic [2:0] p;
    p = p0;
    wr({5'h00, p0}, 1'b0, 8'h00);
    master_u.start();
    master_u.xfer({4'h2, addr_strap, 1'b1}, 1'b1, q, a);
    check("ack_addr_r", {7'h00, a}, 8'h00);
    for (int i = 0; i < n; i++) begin
      master_u.xfer(8'hFF, i == n - 1, q, a);
      check("read_byte", q, exp_byte(p));
      p = (p == 3'h6) ? 3'h0 : p + 3'h1;
    end
    master_u.stop();
    wait_idle();
  endtask : rd
  task automatic t_address();
    logic [7:0] q;
    logic       a;
    for (int s = 0; s < 8; s++) begin
      addr_strap <= 3'(s);
      @(posedge clk);
      master_u.start();
      master_u.xfer({4'h2, 3'(s), 1'b0}, 1'b1, q, a);
      check("ack_match", {7'h00, a}, 8'h00);
      master_u.stop();
      wait_idle();
      master_u.start();
      q = (s % 2) ? {4'h6, 3'(s), 1'b0} : {4'h2, 3'(s + 1), 1'b0};
      master_u.xfer(q, 1'b1, q, a);
      check("ack_other", {7'h00, a}, 8'h01);
      master_u.stop();
      wait_idle();
    end
  endtask : t_address
  task automatic t_modes();
    logic [7:0] v [3];
    logic [7:0] m;
    v = '{8'hA5, 8'h5A, 8'h00};
    for (int i = 0; i < 3; i++) begin
      wr(8'h00, 1'b1, v[i]);
      m = {4'h0, thermal_output_select, reference_check_select,
           self_check_enable, sleep_select};
      check("modes", m, {4'h0, v[i][3:0]});
      rd(3'h0, 1);
    end
  endtask : t_modes
  initial begin
    rst_n = 1'b0;
    addr_strap = 3'h5;
    res_is_high = 1'b1;
    x_s = 16'hFABC;
    t_s = 16'hF123;
    y_s = 16'hF756;
    ctl_exp = 8'h00;
    fails = 0;
    checks = 0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    check("modes_reset", {4'h0, thermal_output_select, reference_check_select,
      self_check_enable, sleep_select}, 8'h00);
    rd(3'h0, 1);
    t_address();
    t_modes();
    wr(8'h00, 1'b1, 8'h00);
    repeat (WAKE_CYCLES) @(posedge clk);
    rd(3'h0, 9);
    wr(8'h00, 1'b1, 8'h08);
    rd(3'h1, 2);
    res_is_high <= 1'b0;
    @(posedge clk);
    rd(3'h3, 2);
    rd(3'h4, 4);
    print_verdict();
  end
endmodule : accel_i2c_slave_regs_tb
bind accel_i2c_slave_regs accel_i2c_slave_regs_props props_u (.clk(clk),
  .rst_n(rst_n), .scl(scl), .sda_in(sda_in), .sda_out(sda_out),
  .sda_oe(sda_oe), .sleep_select(sleep_select),
  .self_check_enable(self_check_enable),
  .reference_check_select(reference_check_select),
  .thermal_output_select(thermal_output_select), .bus_active(bus_active));
